// [pkg/bts_consts.svh]
// Constants of the bit test and bit set executor.
// Assumes one clock edge per clock state.
`ifndef BTS_CONSTS_SVH
`define BTS_CONSTS_SVH
// ----------------------------------------
// Instruction bytes
// ----------------------------------------
`define BTS_PFX_FIRST  8'hdd
`define BTS_PFX_SECOND 8'hfd
`define BTS_PFX_BITOP  8'hcb
`define BTS_MEM_CODE   3'h6
`define BTS_GRP_TEST   2'h1
`define BTS_GRP_SET    2'h3
// ----------------------------------------
// Flag positions
// ----------------------------------------
`define BTS_FLAG_ZERO  6
`define BTS_FLAG_HALF  4
`define BTS_FLAG_SUB   1
`define BTS_FLAG_CARRY 0
// ----------------------------------------
// Clock period in ns and timing in clock states
// ----------------------------------------
`define BTS_CLK_PERIOD_NS 8
`define BTS_T_TEST_IDX 20
`define BTS_T_SET_IDX  23
`define BTS_T_SET_PTR  15
`define BTS_T_SET_REG  8
`endif

// [pkg/bts_pkg.sv]
// Types of the bit test and bit set executor.
// Assumes bts_consts.svh is not needed here.
package bts_pkg;
  typedef enum logic [1:0] {
    BTS_ST_IDLE = 2'b01,
    BTS_ST_RUN  = 2'b10
  } bts_state_t;
  typedef enum logic [1:0] {
    BTS_K_SET_REG = 2'h0,
    BTS_K_SET_PTR = 2'h1,
    BTS_K_TEST_IDX = 2'h2,
    BTS_K_SET_IDX = 2'h3
  } bts_kind_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } bts_mem_req_t;
  typedef logic [7:0][7:0] bts_gpr_t;
endpackage : bts_pkg

// [logic/bts_exec.sv]
// Executor for bit test on indexed memory and bit set on register or memory.
// Assumes memory read data is stable by the last clock state of a read cycle.
`timescale 1ns/1ps
`include "bts_consts.svh"

// Operation
// RULE1: Test with first prefix dd reads at first_index_pair plus signed displacement.
// RULE2: Test with second prefix fd reads at second_index_pair plus signed displacement.
// RULE3: The bit field b selects bit 0 to 7 with bit 0 the least significant.
// RULE4: Test sets zero to the inverted bit, sets half carry, clears subtract, keeps carry.
// RULE5: An indexed test takes 20 clock states in cycles of 4, 4, 3, 5 and 4.
// RULE6: Register set forces the chosen bit of the register to one with flags untouched.
// RULE7: Register codes 000 to 101 are b to l and 111 is the accumulator.
// RULE8: Register set takes 8 clock states in two cycles of 4.
// RULE9: Pointer set forces the bit in the byte at main_pointer_pair, flags untouched.
// RULE10: Pointer set takes 15 clock states in cycles of 4, 4, 4 and 3.
// RULE11: Indexed set forces the bit at first_index_pair plus displacement, flags untouched.
// RULE12: Indexed set takes 23 clock states in cycles of 4, 4, 3, 5, 4 and 3.
// RULE13: Set with prefix fd ends in a byte 11 b 110 and targets second_index_pair plus d.
// RULE14: Pointer set opcode carries 110 in its low three bits.
// RULE15: Set with prefix dd ends in a byte 11 b 110.
// RULE16: Memory set reads the byte then writes it back with only the chosen bit set; the code ORs the chosen bit into the byte read, keeping the other bits.
module bts_exec (
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  arst_n_in,
  // Instruction start
  input  wire logic                  go_in,
  input  wire logic [15:0]           pc_in,
  // Pointer registers
  input  wire logic [15:0]           first_index_pair_in,
  input  wire logic [15:0]           second_index_pair_in,
  input  wire logic [15:0]           main_pointer_pair_in,
  // Register and flag preload
  input  wire logic                  load_in,
  input  wire logic [2:0]            load_sel_in,
  input  wire logic [7:0]            load_data_in,
  input  wire logic                  flags_wr_in,
  input  wire logic [7:0]            flags_data_in,
  // Memory port
  output      bts_pkg::bts_mem_req_t mem_req_out,
  input  wire logic [7:0]            mem_rdata_in,
  // Status
  output      logic                  busy_out,
  output      logic                  done_out,
  output      logic                  ill_out,
  output      logic [7:0]            flags_out,
  output      bts_pkg::bts_gpr_t     regs_out
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction : bit_mask

  function automatic logic [2:0] mc_len(input logic pfx, input logic [2:0] mc);
    mc_len = 3'h4;
    if (pfx) begin
      unique case (mc)
        3'h2: mc_len = 3'h3;
        3'h3: mc_len = 3'h5;
        3'h5: mc_len = 3'h3;
        default: mc_len = 3'h4;
      endcase
    end else if (mc == 3'h3) begin
      mc_len = 3'h3;
    end
  endfunction : mc_len

  // ----------------------------------------
  // State
  // ----------------------------------------
  bts_pkg::bts_state_t   st_q, st_d;
  bts_pkg::bts_kind_t    kind_q, kind_d;
  bts_pkg::bts_mem_req_t mem_q, mem_d;
  bts_pkg::bts_gpr_t     regs_q, regs_d;
  logic [2:0]  t_q, t_d, mc_q, mc_d;
  logic        pfx_q, pfx_d, sec_q, sec_d;
  logic [15:0] pc_q, pc_d, ea_q, ea_d;
  logic [7:0]  opc_q, opc_d, data_q, data_d, flags_q, flags_d;
  logic        done_q, done_d, ill_q, ill_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        last, fin, bad;
  logic [15:0] idx;

  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    mem_d = mem_q;
    mem_d.rd = 1'b0;
    mem_d.wr = 1'b0;
    regs_d = regs_q;
    t_d = t_q;
    mc_d = mc_q;
    pfx_d = pfx_q;
    sec_d = sec_q;
    pc_d = pc_q;
    ea_d = ea_q;
    opc_d = opc_q;
    data_d = data_q;
    flags_d = flags_q;
    fin = 1'b0;
    bad = 1'b0;
    idx = sec_q ? second_index_pair_in : first_index_pair_in;
    last = (t_q == mc_len(pfx_q, mc_q) - 3'h1);
    if (load_in && load_sel_in != `BTS_MEM_CODE) begin
      regs_d[load_sel_in] = load_data_in;
    end
    if (flags_wr_in) begin
      flags_d = flags_data_in;
    end
    unique case (st_q)
      bts_pkg::BTS_ST_IDLE: begin
        if (go_in) begin
          st_d = bts_pkg::BTS_ST_RUN;
          t_d = 3'h0;
          mc_d = 3'h0;
          pc_d = pc_in;
          mem_d.addr = pc_in;
          mem_d.rd = 1'b1;
        end
      end
      bts_pkg::BTS_ST_RUN: begin
        t_d = t_q + 3'h1;
        if (last) begin
          t_d = 3'h0;
          mc_d = mc_q + 3'h1;
          mem_d.addr = pc_q + 16'(mc_q) + 16'h1;
          mem_d.rd = 1'b1;
          if (mc_q == 3'h0) begin
            pfx_d = (mem_rdata_in != `BTS_PFX_BITOP);
            sec_d = (mem_rdata_in == `BTS_PFX_SECOND);
            bad = !(mem_rdata_in == `BTS_PFX_BITOP || mem_rdata_in == `BTS_PFX_FIRST
                    || mem_rdata_in == `BTS_PFX_SECOND);
          end else if (!pfx_q) begin
            unique case (mc_q)
              3'h1: begin
                opc_d = mem_rdata_in;
                bad = (mem_rdata_in[7:6] != `BTS_GRP_SET);
                if (mem_rdata_in[2:0] != `BTS_MEM_CODE) begin
                  // RULE6 register bit set
                  // RULE7 register code index
                  regs_d[mem_rdata_in[2:0]] = regs_q[mem_rdata_in[2:0]]
                                              | (bad ? 8'h00 : bit_mask(mem_rdata_in[5:3]));
                  kind_d = bts_pkg::BTS_K_SET_REG;
                  fin = 1'b1;
                end else begin
                  // RULE14 memory code
                  // RULE9 pointer addressed read
                  kind_d = bts_pkg::BTS_K_SET_PTR;
                  ea_d = main_pointer_pair_in;
                  mem_d.addr = main_pointer_pair_in;
                end
              end
              3'h2: begin
                // RULE16 read then write back
                data_d = mem_rdata_in;
                mem_d.addr = ea_q;
                mem_d.rd = 1'b0;
                mem_d.wr = 1'b1;
                mem_d.wdata = mem_rdata_in | bit_mask(opc_q[5:3]);
              end
              default: fin = 1'b1;
            endcase
          end else begin
            unique case (mc_q)
              3'h1: bad = (mem_rdata_in != `BTS_PFX_BITOP);
              // RULE1 first index plus displacement
              // RULE2 second index plus displacement
              3'h2: ea_d = 16'(idx + {{8{mem_rdata_in[7]}}, mem_rdata_in});
              3'h3: begin
                // RULE13 indexed opcode layout
                // RULE15 indexed opcode layout
                opc_d = mem_rdata_in;
                bad = (mem_rdata_in[2:0] != `BTS_MEM_CODE)
                      || !(mem_rdata_in[7:6] == `BTS_GRP_SET
                           || mem_rdata_in[7:6] == `BTS_GRP_TEST);
                kind_d = (mem_rdata_in[7:6] == `BTS_GRP_SET) ? bts_pkg::BTS_K_SET_IDX
                                                              : bts_pkg::BTS_K_TEST_IDX;
                mem_d.addr = ea_q;
              end
              3'h4: begin
                data_d = mem_rdata_in;
                if (kind_q == bts_pkg::BTS_K_TEST_IDX) begin
                  // RULE3 bit select
                  // RULE4 test flag effects
                  flags_d[`BTS_FLAG_ZERO] = ~mem_rdata_in[opc_q[5:3]];
                  flags_d[`BTS_FLAG_HALF] = 1'b1;
                  flags_d[`BTS_FLAG_SUB] = 1'b0;
                  fin = 1'b1;
                end else begin
                  // RULE11 indexed read modify write
                  mem_d.addr = ea_q;
                  mem_d.rd = 1'b0;
                  mem_d.wr = 1'b1;
                  mem_d.wdata = mem_rdata_in | bit_mask(opc_q[5:3]);
                end
              end
              default: fin = 1'b1;
            endcase
          end
          // RULE5 cycle sequence
          // RULE8 cycle sequence
          // RULE10 cycle sequence
          // RULE12 cycle sequence
          if (fin || bad) begin
            st_d = bts_pkg::BTS_ST_IDLE;
            mem_d.rd = 1'b0;
            mem_d.wr = 1'b0;
          end
        end
      end
      default: st_d = bts_pkg::BTS_ST_IDLE;
    endcase
    done_d = (st_q == bts_pkg::BTS_ST_RUN) && (st_d == bts_pkg::BTS_ST_IDLE);
    ill_d = bad;
    cnt_d = (st_q == bts_pkg::BTS_ST_IDLE) ? 6'h1 : (done_d ? cnt_q : cnt_q + 6'h1);
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= bts_pkg::BTS_ST_IDLE;
      kind_q <= bts_pkg::BTS_K_SET_REG;
      mem_q <= '0;
      regs_q <= '0;
      t_q <= 3'h0;
      mc_q <= 3'h0;
      pfx_q <= 1'b0;
      sec_q <= 1'b0;
      pc_q <= 16'h0000;
      ea_q <= 16'h0000;
      opc_q <= 8'h00;
      data_q <= 8'h00;
      flags_q <= 8'h00;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      cnt_q <= 6'h0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      mem_q <= mem_d;
      regs_q <= regs_d;
      t_q <= t_d;
      mc_q <= mc_d;
      pfx_q <= pfx_d;
      sec_q <= sec_d;
      pc_q <= pc_d;
      ea_q <= ea_d;
      opc_q <= opc_d;
      data_q <= data_d;
      flags_q <= flags_d;
      done_q <= done_d;
      ill_q <= ill_d;
      cnt_q <= cnt_d;
    end
  end

  assign mem_req_out = mem_q;
  assign busy_out = st_q[1];
  assign done_out = done_q;
  assign ill_out = ill_q;
  assign flags_out = flags_q;
  assign regs_out = regs_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_TEST_IDX_LEN: assert property ( // RULE5
    done_q && !ill_q && kind_q == bts_pkg::BTS_K_TEST_IDX |-> cnt_q == 6'(`BTS_T_TEST_IDX))
    else $error("indexed test length wrong");
  AST_SET_IDX_LEN: assert property ( // RULE12
    done_q && !ill_q && kind_q == bts_pkg::BTS_K_SET_IDX |-> cnt_q == 6'(`BTS_T_SET_IDX))
    else $error("indexed set length wrong");
  AST_SET_PTR_LEN: assert property ( // RULE10
    done_q && !ill_q && kind_q == bts_pkg::BTS_K_SET_PTR |-> cnt_q == 6'(`BTS_T_SET_PTR))
    else $error("pointer set length wrong");
  AST_SET_REG_LEN: assert property ( // RULE8
    done_q && !ill_q && kind_q == bts_pkg::BTS_K_SET_REG |-> cnt_q == 6'(`BTS_T_SET_REG))
    else $error("register set length wrong");
  AST_TEST_FLAGS: assert property ( // RULE4
    done_q && !ill_q && kind_q == bts_pkg::BTS_K_TEST_IDX && !$past(flags_wr_in)
    |-> flags_q[`BTS_FLAG_ZERO] == ~data_q[opc_q[5:3]] && flags_q[`BTS_FLAG_HALF]
        && !flags_q[`BTS_FLAG_SUB] && flags_q[`BTS_FLAG_CARRY] == $past(flags_q[0]))
    else $error("test flags wrong");
  AST_SET_KEEPS_FLAGS: assert property ( // RULE9
    busy_out && kind_d != bts_pkg::BTS_K_TEST_IDX && mc_q > 3'h0 && !flags_wr_in
    |=> $stable(flags_q))
    else $error("set changed flags");
  AST_WRITE_BACK: assert property ( // RULE16
    mem_q.wr |-> mem_q.addr == ea_q && mem_q.wdata == (data_q | bit_mask(opc_q[5:3])))
    else $error("write back mismatch");
  AST_IDX_ADDR: assert property ( // RULE1
    busy_out && pfx_q && mc_q == 3'h4 && mem_q.rd |-> mem_q.addr == ea_q
    && ea_q == $past(idx, 6) + 16'($signed($past(mem_rdata_in, 6))))
    else $error("indexed address wrong");
  AST_REG_SET: assert property ( // RULE6
    done_q && !ill_q && kind_q == bts_pkg::BTS_K_SET_REG |-> regs_q[opc_q[2:0]][opc_q[5:3]])
    else $error("register bit not set");

  COV_TEST: cover property (done_q && !ill_q && kind_q == bts_pkg::BTS_K_TEST_IDX);
  COV_SET_IDX: cover property (done_q && !ill_q && kind_q == bts_pkg::BTS_K_SET_IDX);
  COV_SET_PTR: cover property (done_q && !ill_q && kind_q == bts_pkg::BTS_K_SET_PTR);
  COV_ILL: cover property (done_q && ill_q);
endmodule : bts_exec

// [verification/bts_tb.sv]
// Self-checking bench for the bit test and bit set executor.
// Assumes bts_consts.svh on the include path and bts_pkg compiled first.
`timescale 1ns/1ps
`include "bts_consts.svh"

module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  sys_clk_in           = 1'b0;
  logic                  arst_n_in            = 1'b0;
  logic                  go_in                = 1'b0;
  logic [15:0]           pc_in                = 16'h0100;
  logic [15:0]           first_index_pair_in  = 16'h2000;
  logic [15:0]           second_index_pair_in = 16'h4000;
  logic [15:0]           main_pointer_pair_in = 16'h3000;
  logic                  load_in              = 1'b0;
  logic [2:0]            load_sel_in          = 3'h0;
  logic [7:0]            load_data_in         = 8'h00;
  logic                  flags_wr_in          = 1'b0;
  logic [7:0]            flags_data_in        = 8'h00;
  bts_pkg::bts_mem_req_t mem_req_out;
  logic [7:0]            mem_rdata_in         = 8'h00;
  logic                  busy_out;
  logic                  done_out;
  logic                  ill_out;
  logic [7:0]            flags_out;
  bts_pkg::bts_gpr_t     regs_out;
  logic [7:0]            mem [0:65535];
  int                    err_total   = 0;
  int                    check_count = 0;
  int                    wr_cnt      = 0;
  logic [15:0]           wr_addr     = 16'h0000;
  int                    cyc         = 0;

  bts_exec i_bts_exec (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .go_in(go_in), .pc_in(pc_in),
    .first_index_pair_in(first_index_pair_in), .second_index_pair_in(second_index_pair_in),
    .main_pointer_pair_in(main_pointer_pair_in), .load_in(load_in), .load_sel_in(load_sel_in),
    .load_data_in(load_data_in), .flags_wr_in(flags_wr_in), .flags_data_in(flags_data_in),
    .mem_req_out(mem_req_out), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out),
    .done_out(done_out), .ill_out(ill_out), .flags_out(flags_out), .regs_out(regs_out)
  );

  // ----------------------------------------
  // Clock, memory and timeout
  // ----------------------------------------
  always #(`BTS_CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;

  always @(negedge sys_clk_in) begin
    if (mem_req_out.rd === 1'b1) begin
      mem_rdata_in = mem[mem_req_out.addr];
    end
    if (mem_req_out.wr === 1'b1) begin
      mem[mem_req_out.addr] = mem_req_out.wdata;
      wr_addr = mem_req_out.addr;
      wr_cnt++;
    end
  end

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("ERROR timeout expected done seen hang");
      print_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic set_flags(input logic [7:0] f);
    flags_data_in = f;
    flags_wr_in   = 1'b1;
    @(negedge sys_clk_in);
    flags_wr_in   = 1'b0;
  endtask : set_flags

  task automatic load_reg(input logic [2:0] r, input logic [7:0] v);
    load_sel_in  = r;
    load_data_in = v;
    load_in      = 1'b1;
    @(negedge sys_clk_in);
    load_in      = 1'b0;
  endtask : load_reg

  // Places the bytes at pc_in, starts, and counts states to done
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input logic [7:0] b3, input int len, input logic ill_exp);
    int n;
    mem[pc_in]         = b0;
    mem[pc_in + 16'h1] = b1;
    mem[pc_in + 16'h2] = b2;
    mem[pc_in + 16'h3] = b3;
    wr_cnt = 0;
    go_in  = 1'b1;
    @(negedge sys_clk_in);
    go_in  = 1'b0;
    n      = 0;
    chk("busy", 16'h1, {15'h0, busy_out});
    while (done_out !== 1'b1 && n < 60) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (len > 0) chk("states", 16'(len), 16'(n));
    chk("idle", 16'h0, {15'h0, busy_out});
    chk("ill", {15'h0, ill_exp}, {15'h0, ill_out});
  endtask : run

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    @(negedge sys_clk_in);
    // Indexed bit test, both pairs, every bit, signed displacement
    for (int b = 0; b < 8; b++) begin
      logic [15:0] ea;
      logic [7:0]  fe;
      ea = (b % 2) ? 16'h3ffc : 16'h2004;
      mem[ea] = 8'h5a;
      set_flags(8'ha3);
      fe = 8'ha3;
      fe[`BTS_FLAG_ZERO] = ~mem[ea][b];
      fe[`BTS_FLAG_HALF] = 1'b1;
      fe[`BTS_FLAG_SUB]  = 1'b0;
      run((b % 2) ? `BTS_PFX_SECOND : `BTS_PFX_FIRST, `BTS_PFX_BITOP,
          (b % 2) ? 8'hfc : 8'h04, {2'b01, 3'(b), 3'b110}, `BTS_T_TEST_IDX,
          1'b0);
      chk("test flags", {8'h0, fe}, {8'h0, flags_out});
      chk("test byte", 16'h005a, {8'h0, mem[ea]});
      chk("test writes", 16'h0, 16'(wr_cnt));
    end
    $display("test done: indexed bit test");
    // Register bit set on every register code
    set_flags(8'h5e);
    for (int i = 0; i < 7; i++) begin
      logic [2:0] r;
      logic [2:0] b;
      r = (i == 6) ? 3'h7 : 3'(i);
      b = (i == 6) ? 3'h7 : 3'(i + 1);
      load_reg(r, 8'h24);
      run(`BTS_PFX_BITOP, {2'b11, b, r}, 8'h00, 8'h00, `BTS_T_SET_REG, 1'b0);
      chk("reg value", {8'h0, 8'h24 | (8'h01 << b)}, {8'h0, regs_out[r]});
      chk("reg flags", 16'h005e, {8'h0, flags_out});
    end
    $display("test done: register bit set");
    // Pointer bit set
    mem[16'h3000] = 8'h81;
    run(`BTS_PFX_BITOP, {2'b11, 3'h4, `BTS_MEM_CODE}, 8'h00, 8'h00, `BTS_T_SET_PTR,
        1'b0);
    chk("ptr byte", 16'h0091, {8'h0, mem[16'h3000]});
    chk("ptr writes", 16'h1, 16'(wr_cnt));
    chk("ptr addr", 16'h3000, wr_addr);
    chk("ptr flags", 16'h005e, {8'h0, flags_out});
    $display("test done: pointer bit set");
    // Indexed bit set, extreme displacements
    for (int p = 0; p < 2; p++) begin
      logic [15:0] ea;
      ea = p ? 16'h407f : 16'h1f80;
      mem[ea] = 8'h00;
      run(p ? `BTS_PFX_SECOND : `BTS_PFX_FIRST, `BTS_PFX_BITOP, p ? 8'h7f : 8'h80,
          {2'b11, p ? 3'h7 : 3'h0, 3'b110}, `BTS_T_SET_IDX, 1'b0);
      chk("idx byte", p ? 16'h0080 : 16'h0001, {8'h0, mem[ea]});
      chk("idx addr", ea, wr_addr);
      chk("idx writes", 16'h1, 16'(wr_cnt));
      chk("idx flags", 16'h005e, {8'h0, flags_out});
    end
    $display("test done: indexed bit set");
    // Refused encodings
    run(`BTS_PFX_FIRST, `BTS_PFX_BITOP, 8'h05, 8'hc7, 0, 1'b1);
    chk("bad low bits writes", 16'h0, 16'(wr_cnt));
    run(8'h00, 8'h00, 8'h00, 8'h00, 0, 1'b1);
    run(`BTS_PFX_BITOP, 8'h47, 8'h00, 8'h00, 0, 1'b1);
    chk("bad reg keep", 16'h00a4, {8'h0, regs_out[7]});
    run(`BTS_PFX_SECOND, 8'h00, 8'h00, 8'h00, 0, 1'b1);
    $display("test done: refused encodings");
    print_verdict();
  end
endmodule : testbench
